// File: core/rsp_pkg.sv
// constants, register map and types shared by the radio serial port master
package rsp_pkg;

  // ----------------------------------------------------------------------
  // register addresses on the special function register port
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h84;
  localparam logic [7:0] ADDR_RATE = 8'h85;
  localparam logic [7:0] ADDR_DATA = 8'h86;
  localparam logic [7:0] ADDR_CONTROL = 8'hB0;

  // ----------------------------------------------------------------------
  // serial_config field positions
  // ----------------------------------------------------------------------
  localparam int CFG_BUSY_BIT = 7;
  localparam int CFG_MASTER_BIT = 6;
  localparam int CFG_PHASE_BIT = 5;
  localparam int CFG_POLARITY_BIT = 4;
  localparam logic [3:0] CFG_RESERVED_READ = 4'h0;

  // ----------------------------------------------------------------------
  // serial_control field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTL_FLAG_LSB = 4;
  localparam int CTL_SEL_HI_BIT = 3;
  localparam int CTL_SEL_LO_BIT = 2;
  localparam int CTL_TX_EMPTY_BIT = 1;
  localparam int CTL_ENABLE_BIT = 0;
  localparam logic [1:0] SEL_MODE_RESET = 2'h1;
  localparam logic [1:0] SEL_MODE_FAULT = 2'h1;

  // sticky flag indices, flag i reads at control bit CTL_FLAG_LSB + i
  localparam int NUM_FLAGS = 4;
  localparam int FLAG_OVERRUN = 0;
  localparam int FLAG_MODE_FAULT = 1;
  localparam int FLAG_COLLISION = 2;
  localparam int FLAG_DONE = 3;

  // ----------------------------------------------------------------------
  // serial clock timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int SCK_MAX_KHZ = 12500;
  localparam int MIN_HALF_INT = (CLK_FREQ_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  localparam logic [8:0] MIN_HALF = 9'(MIN_HALF_INT > 0 ? MIN_HALF_INT : 1);
  localparam logic [8:0] RATE_ONE = 9'h001;
  localparam logic [4:0] TICK_LAST_PHASE0 = 5'h0F;
  localparam logic [4:0] TICK_LAST_PHASE1 = 5'h10;

  // shift engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } rsp_eng_state_t;

endpackage

// File: core/rsp_eng_if.sv
// link between the register side and the serial shift engine
`timescale 1ns/1ps
interface rsp_eng_if;
  logic start;
  logic enable;
  logic [7:0] tx_byte;
  logic [8:0] half;
  logic phase;
  logic polarity;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic sck;
  logic mosi;

  modport ctl (
    output start, enable, tx_byte, half, phase, polarity,
    input busy, done, rx_byte, sck, mosi
  );
  modport eng (
    input start, enable, tx_byte, half, phase, polarity,
    output busy, done, rx_byte, sck, mosi
  );
endinterface

// File: core/rsp_shift_engine.sv
// serial shift engine: clock generation, msb-first shifting and miso capture
`timescale 1ns/1ps
module rsp_shift_engine
  import rsp_pkg::*;
#(
  parameter int HALF_W = 9
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic miso_in,
  rsp_eng_if.eng eng_if
);

  // the half period counter must hold the widest rate setting plus one
  if (HALF_W != 9) begin : g_bad_width
    $error("rsp_shift_engine: HALF_W must be 9");
  end

  rsp_eng_state_t state, next_state;
  logic [HALF_W-1:0] half_cnt, next_half_cnt;
  logic [4:0] tick, next_tick;
  logic [7:0] sreg, next_sreg;
  logic [7:0] rx_byte, next_rx_byte;
  logic sck_lvl, next_sck_lvl;
  logic sck, next_sck;
  logic done, next_done;
  logic capture;
  logic [4:0] tick_last;

  // ----------------------------------------------------------------------
  // next state of the engine
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_tick = tick;
    next_sreg = sreg;
    next_rx_byte = rx_byte;
    next_sck_lvl = sck_lvl;
    next_done = 1'b0;
    capture = 1'b0;
    tick_last = eng_if.phase ? TICK_LAST_PHASE1 : TICK_LAST_PHASE0;
    unique case (state)
      ST_IDLE: begin
        next_sck_lvl = 1'b0;
        if (eng_if.start && eng_if.enable) begin // [R18]
          next_state = ST_RUN;
          next_sreg = eng_if.tx_byte;
          next_half_cnt = eng_if.half - RATE_ONE; // [R20]
          next_tick = 5'h00;
        end
      end
      ST_RUN: begin
        if (half_cnt != '0) begin
          next_half_cnt = half_cnt - RATE_ONE;
        end else begin
          next_half_cnt = eng_if.half - RATE_ONE;
          // the half period ends at this tick; miso is taken in the last cycle of the bit [R13]
          capture = eng_if.phase ? (!tick[0] && tick != 5'h00) : tick[0]; // [R7]
          if (capture) begin
            next_sreg = {sreg[6:0], miso_in}; // [R19]
          end
          if (tick != TICK_LAST_PHASE1) begin
            next_sck_lvl = !sck_lvl;
          end
          if (tick == tick_last) begin
            next_state = ST_IDLE;
            next_done = 1'b1; // [R1]
            next_rx_byte = {sreg[6:0], miso_in}; // [R19]
          end else begin
            next_tick = tick + 5'h01;
          end
        end
      end
    endcase
    // a disabled port drops any transfer and parks the clock [R21]
    if (!eng_if.enable) begin
      next_state = ST_IDLE;
      next_sck_lvl = 1'b0;
      next_done = 1'b0;
    end
    next_sck = next_sck_lvl ^ eng_if.polarity; // [R8]
  end

  // ----------------------------------------------------------------------
  // engine registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      half_cnt <= '0;
      tick <= 5'h00;
      sreg <= 8'h00;
      rx_byte <= 8'h00;
      sck_lvl <= 1'b0;
      sck <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      tick <= next_tick;
      sreg <= next_sreg;
      rx_byte <= next_rx_byte;
      sck_lvl <= next_sck_lvl;
      sck <= next_sck;
      done <= next_done;
    end
  end

  assign eng_if.busy = (state == ST_RUN); // [R11]
  assign eng_if.done = done;
  assign eng_if.rx_byte = rx_byte;
  assign eng_if.sck = sck;
  assign eng_if.mosi = sreg[7]; // [R19]

endmodule

// File: core/rsp_spi_master.sv
// register side of the radio serial port master: registers, flags and buffers
`timescale 1ns/1ps

// Overview of operation
// R1: every finished byte sets done flag
// R2: flags clear only by software writing zero
// R3: data write while buffer full: collision, dropped
// R4: select low, master, mode 01 sets fault
// R5: mode fault clears master and port enables
// R6: slave completion with unread byte: overrun, drop
// R7: phase bit picks first or second edge
// R8: polarity bit sets serial clock idle level
// R9: software keeps phase and polarity zero
// R10: bit rate capped at 12.5 MHz, half clock
// R11: busy bit reads one during transfer
// R12: software sets master enable before use
// R13: miso sampled one cycle before bit end
// R14: software keeps select mode field at 00b
// R15: buffer empty drops on write, rises on move
// R16: low four config bits read zero, ignore writes
// R17: software writes zero to control bit four
// R18: buffered byte starts transfer when shifter free
// R19: msb first, received byte into receive buffer
// R20: clock is system clock over 2(rate+1); rates 0 to 6 run at system clock over 16
// R21: disabled port starts nothing, clock stays idle
module rsp_spi_master
  import rsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic miso_in,
  input wire logic nss_in,
  output logic [7:0] sfr_rdata_out,
  output logic sck_out,
  output logic mosi_out,
  output logic irq_out
);

  rsp_eng_if eng_bus ();

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  // software settings, current and next
  logic master_enable, next_master_enable;
  logic clock_phase_sel, next_clock_phase_sel;
  logic clock_polarity_sel, next_clock_polarity_sel;
  logic [1:0] select_mode_field, next_select_mode_field;
  logic port_enable, next_port_enable;
  logic [7:0] clock_rate_reg, next_clock_rate_reg;

  // buffers on either side of the shifter
  logic [7:0] tx_buf, next_tx_buf;
  logic tx_full, next_tx_full;
  logic [7:0] rx_buf, next_rx_buf;
  logic rx_unread, next_rx_unread;

  // start request, sticky flags and bus answers
  logic start, next_start;
  logic [NUM_FLAGS-1:0] flags, next_flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [7:0] rdata, next_rdata;
  logic irq, next_irq;

  // decoded strobes and derived status
  logic wr_config, wr_rate, wr_data, wr_control, rd_data;
  logic mode_fault;
  logic port_busy;
  logic [8:0] rate_half;
  logic [7:0] config_view, control_view;

  // ----------------------------------------------------------------------
  // decode and derived status
  // ----------------------------------------------------------------------
  // one strobe per access, decoded in the cycle it is taken
  assign wr_config = sfr_wr_in && (sfr_addr_in == ADDR_CONFIG);
  assign wr_rate = sfr_wr_in && (sfr_addr_in == ADDR_RATE);
  assign wr_data = sfr_wr_in && (sfr_addr_in == ADDR_DATA);
  assign wr_control = sfr_wr_in && (sfr_addr_in == ADDR_CONTROL);
  assign rd_data = sfr_rd_in && (sfr_addr_in == ADDR_DATA);

  // a pending start counts as busy, so the cycle before the engine runs reads busy too; between burst bytes busy reads zero for one cycle
  assign port_busy = eng_bus.busy || start; // [R11]

  // the select pin is taken as synchronous to the system clock
  // the select pin only matters in the multi-master select mode
  assign mode_fault = !nss_in && master_enable
    && (select_mode_field == SEL_MODE_FAULT); // [R4]

  // slow settings pass through, fast ones are held at the rate ceiling [R10]
  // rate 0 to 6 therefore run at the same speed as rate 7
  assign rate_half = ({1'b0, clock_rate_reg} + RATE_ONE < MIN_HALF)
    ? MIN_HALF : {1'b0, clock_rate_reg} + RATE_ONE; // [R20]

  // ----------------------------------------------------------------------
  // register read views
  // ----------------------------------------------------------------------
  always_comb begin
    config_view = 8'h00;
    config_view[CFG_BUSY_BIT] = port_busy; // [R11]
    config_view[CFG_MASTER_BIT] = master_enable;
    config_view[CFG_PHASE_BIT] = clock_phase_sel;
    config_view[CFG_POLARITY_BIT] = clock_polarity_sel;
    config_view[3:0] = CFG_RESERVED_READ; // [R16]

    // control view, bit 4 carries the overrun flag
    control_view = 8'h00;
    control_view[CTL_FLAG_LSB+NUM_FLAGS-1:CTL_FLAG_LSB] = flags;
    control_view[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT] = select_mode_field;
    control_view[CTL_TX_EMPTY_BIT] = !tx_full; // [R15]
    control_view[CTL_ENABLE_BIT] = port_enable;
  end

  // ----------------------------------------------------------------------
  // hardware flag events
  // ----------------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    flag_set[FLAG_DONE] = eng_bus.done; // [R1]
    flag_set[FLAG_COLLISION] = wr_data && tx_full; // [R3]
    flag_set[FLAG_MODE_FAULT] = mode_fault; // [R4]
    // overrun needs a byte to finish after master mode was left
    flag_set[FLAG_OVERRUN] = eng_bus.done && !master_enable && rx_unread; // [R6]
  end

  // ----------------------------------------------------------------------
  // sticky flags: a set in the clearing cycle wins over the write
  // ----------------------------------------------------------------------
  // one identical cell per flag, overrun flag at index zero
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_comb begin
        next_flags[gi] = flags[gi];
        if (wr_control) begin
          next_flags[gi] = sfr_wdata_in[CTL_FLAG_LSB + gi]; // [R2]
        end
        if (flag_set[gi]) begin
          next_flags[gi] = 1'b1; // [R2]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // configuration, control and rate registers
  // ----------------------------------------------------------------------
  always_comb begin
    next_master_enable = master_enable;
    next_clock_phase_sel = clock_phase_sel;
    next_clock_polarity_sel = clock_polarity_sel;
    next_select_mode_field = select_mode_field;
    next_port_enable = port_enable;
    next_clock_rate_reg = clock_rate_reg;
    if (wr_config) begin
      // busy and the low four bits are read-only, writes fall away [R16]
      next_master_enable = sfr_wdata_in[CFG_MASTER_BIT];
      next_clock_phase_sel = sfr_wdata_in[CFG_PHASE_BIT]; // [R7]
      next_clock_polarity_sel = sfr_wdata_in[CFG_POLARITY_BIT]; // [R8]
    end

    // select field is stored as written; only 01 arms the fault
    if (wr_control) begin
      next_select_mode_field = sfr_wdata_in[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT];
      next_port_enable = sfr_wdata_in[CTL_ENABLE_BIT];
    end

    if (wr_rate) begin
      next_clock_rate_reg = sfr_wdata_in; // [R20]
    end
    // the fault hands the bus over, even against a same-cycle write [R5]
    if (mode_fault) begin
      next_master_enable = 1'b0; // [R5]
      next_port_enable = 1'b0; // [R5]
    end
  end

  // ----------------------------------------------------------------------
  // transmit buffer, start request and receive buffer
  // ----------------------------------------------------------------------
  always_comb begin
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_start = 1'b0;
    next_rx_buf = rx_buf;
    next_rx_unread = rx_unread;
    // a full buffer refuses the byte and keeps its contents [R3]
    if (wr_data && !tx_full) begin
      next_tx_buf = sfr_wdata_in;
      next_tx_full = 1'b1; // [R15]
    end

    // move into a free shifter only when enabled as master [R18]
    if (tx_full && !port_busy && master_enable && port_enable) begin // [R21]
      next_start = 1'b1; // [R18]
      next_tx_full = 1'b0; // [R15]
    end

    // reading the data register marks the byte as taken
    if (rd_data) begin
      next_rx_unread = 1'b0;
    end

    if (eng_bus.done) begin
      if (master_enable || !rx_unread) begin
        next_rx_buf = eng_bus.rx_byte; // [R19]
        next_rx_unread = 1'b1;
      end
      // otherwise the old byte stays and the new one is lost [R6]
    end
  end

  // ----------------------------------------------------------------------
  // read data and interrupt request
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        ADDR_CONFIG: next_rdata = config_view;
        ADDR_RATE: next_rdata = clock_rate_reg;
        ADDR_DATA: next_rdata = rx_buf; // [R19]
        ADDR_CONTROL: next_rdata = control_view;
        default: next_rdata = 8'h00;
      endcase
    end

    // no enable gate here: any set flag raises the request
    next_irq = |next_flags; // [R1]
  end

  // ----------------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------------
  // reset values give the register views software expects
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      master_enable <= 1'b0;
      clock_phase_sel <= 1'b0;
      clock_polarity_sel <= 1'b0;
      select_mode_field <= SEL_MODE_RESET;
      port_enable <= 1'b0;
      clock_rate_reg <= 8'h00;

      tx_buf <= 8'h00;
      tx_full <= 1'b0;
      rx_buf <= 8'h00;
      rx_unread <= 1'b0;

      start <= 1'b0;
      flags <= '0;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      master_enable <= next_master_enable;
      clock_phase_sel <= next_clock_phase_sel;
      clock_polarity_sel <= next_clock_polarity_sel;
      select_mode_field <= next_select_mode_field;
      port_enable <= next_port_enable;
      clock_rate_reg <= next_clock_rate_reg;

      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      rx_buf <= next_rx_buf;
      rx_unread <= next_rx_unread;

      start <= next_start;
      flags <= next_flags;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------------
  // settings act on the engine at once, so change them only between bytes
  assign eng_bus.start = start;
  assign eng_bus.enable = port_enable; // [R21]
  assign eng_bus.tx_byte = tx_buf;
  assign eng_bus.half = rate_half;
  assign eng_bus.phase = clock_phase_sel;
  assign eng_bus.polarity = clock_polarity_sel;

  rsp_shift_engine #(
    .HALF_W(9)
  ) u_engine (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .miso_in(miso_in),
    .eng_if(eng_bus.eng)
  );

  // all pins below leave straight from flip-flops
  assign sfr_rdata_out = rdata;
  assign sck_out = eng_bus.sck;
  assign mosi_out = eng_bus.mosi;
  assign irq_out = irq;

endmodule

// File: tb/rsp_spi_master_properties.sv
// assertion checker for the radio serial port master, bound to its top ports
`timescale 1ns/1ps
module rsp_spi_master_chk
  import rsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic miso_in,
  input wire logic nss_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sck_out,
  input wire logic mosi_out,
  input wire logic irq_out
);
  // ----------------------------------------------------------------------
  // port view of the programmed state
  // ----------------------------------------------------------------------
  logic sck_q, pol_q, mst_q, en_q, chg, cfg_wr, ctl_wr, fault;
  logic [1:0] sel_q;
  logic [7:0] rate_q;
  logic [8:0] half;
  logic [9:0] quiet;
  logic [4:0] tog_cnt;

  // decoded strokes; half period mirrors the clamp at the rate ceiling
  assign chg = sck_out != sck_q;
  assign cfg_wr = sfr_wr_in && sfr_addr_in == ADDR_CONFIG;
  assign ctl_wr = sfr_wr_in && sfr_addr_in == ADDR_CONTROL;
  assign fault = !nss_in && mst_q && sel_q == SEL_MODE_FAULT;
  assign half = (rate_q < 8'h07) ? 9'h008 : {1'b0, rate_q} + RATE_ONE;

  // shadow registers; quiet also restarts on config writes, which may move the idle level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_q <= 1'b0;
      pol_q <= 1'b0;
      mst_q <= 1'b0;
      en_q <= 1'b0;
      sel_q <= SEL_MODE_RESET;
      rate_q <= 8'h00;
      quiet <= 10'h000;
      tog_cnt <= 5'h00;
    end else begin
      sck_q <= sck_out;
      pol_q <= cfg_wr ? sfr_wdata_in[CFG_POLARITY_BIT] : pol_q;
      mst_q <= fault ? 1'b0 : (cfg_wr ? sfr_wdata_in[CFG_MASTER_BIT] : mst_q);
      en_q <= fault ? 1'b0 : (ctl_wr ? sfr_wdata_in[CTL_ENABLE_BIT] : en_q);
      sel_q <= ctl_wr ? sfr_wdata_in[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT] : sel_q;
      rate_q <= (sfr_wr_in && sfr_addr_in == ADDR_RATE) ? sfr_wdata_in : rate_q;
      quiet <= (chg || cfg_wr) ? 10'h000 : (quiet == 10'h3FF ? quiet : quiet + 10'h001);
      if (tog_cnt == 5'h10 || (quiet >= 10'h104 && !chg)) begin
        tog_cnt <= 5'h00;
      end else if (chg) begin
        tog_cnt <= tog_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  cfg_reserved_a: assert property (
    sfr_rd_in && sfr_addr_in == ADDR_CONFIG |=> sfr_rdata_out[3:0] == 4'h0)
    else $error("config low bits read nonzero");
  flag_sticky_a: assert property (
    irq_out && !ctl_wr && !$past(ctl_wr) |=> irq_out)
    else $error("flag dropped without a control write");
  idle_level_a: assert property (
    quiet >= 10'h12C |-> sck_out == pol_q)
    else $error("idle serial clock differs from polarity");
  done_irq_a: assert property (
    tog_cnt == 5'h10 |-> ##[0:300] irq_out)
    else $error("byte finished without done flag");
  fault_irq_a: assert property (
    fault |-> ##[1:3] irq_out)
    else $error("mode fault not flagged");
  sck_spacing_a: assert property (
    chg && tog_cnt != 5'h00 |-> quiet == {1'b0, half} - 10'h001)
    else $error("serial clock half period wrong");
  rate_ceiling_a: assert property (
    $changed(sck_out) |=> $stable(sck_out) [*7])
    else $error("serial clock faster than ceiling");
  disabled_quiet_a: assert property (
    (!en_q && !cfg_wr) [*4] |=> !chg)
    else $error("serial clock moved while port disabled");

  cover property (tog_cnt == 5'h10);
  cover property (fault);
  cover property (quiet >= 10'h12C && pol_q);
endmodule

bind rsp_spi_master rsp_spi_master_chk u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .miso_in(miso_in), .nss_in(nss_in),
  .sfr_rdata_out(sfr_rdata_out), .sck_out(sck_out), .mosi_out(mosi_out), .irq_out(irq_out)
);

// File: tb/rsp_radio_model.sv
// behavioural model of the radio side serial slave, clock mode zero only
`timescale 1ns/1ps
module rsp_radio_model (
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic nss_in,
  input wire logic [7:0] reply_in,
  output logic miso_out,
  output logic [7:0] got_out,
  output int count_out
);
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  int bits = 0;

  initial begin
    got_out = 8'h00;
    count_out = 0;
  end

  // reply is latched as the select falls; each byte of a burst repeats it
  always @(negedge nss_in) begin
    tx_sh = reply_in;
    bits = 0;
  end

  // released line goes to the pull-up level rather than holding the last bit
  assign miso_out = nss_in ? 1'b1 : tx_sh[7];

  // capture on the rising serial clock, msb first
  always @(posedge sck_in) begin
    if (!nss_in) begin
      rx_sh = {rx_sh[6:0], mosi_in};
      bits++;
      if (bits == 8) begin
        got_out = rx_sh;
        count_out++;
        bits = 0;
      end
    end
  end

  // next bit goes out on the falling clock; rotation restores the reply
  always @(negedge sck_in) begin
    if (!nss_in) begin
      tx_sh = {tx_sh[6:0], tx_sh[7]};
    end
  end
endmodule

// File: tb/testbench.sv
// self-checking bench for the radio serial port master
`timescale 1ns/1ps
module testbench
  import rsp_pkg::*;
();
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic nss_in = 1'b1;
  logic [7:0] reply = 8'h00;
  logic miso_in, sck_out, mosi_out, irq_out;
  logic [7:0] sfr_rdata_out, got, v;
  int n_rx;
  int bad_count = 0;
  int n_compared = 0;

  always #2.5 clk_in = ~clk_in;

  rsp_spi_master DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .miso_in(miso_in), .nss_in(nss_in),
    .sfr_rdata_out(sfr_rdata_out), .sck_out(sck_out), .mosi_out(mosi_out), .irq_out(irq_out)
  );
  rsp_radio_model u_radio (
    .sck_in(sck_out), .mosi_in(mosi_out), .nss_in(nss_in), .reply_in(reply),
    .miso_out(miso_in), .got_out(got), .count_out(n_rx)
  );

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic hung();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // one strobe cycle, then a released cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    #1 v = sfr_rdata_out;
    check(v & mask, exp);
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 2000 && n_rx < n; i++) @(posedge clk_in);
    if (n_rx < n) hung();
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rc(ADDR_CONFIG, 8'hFF, 8'h00);
    rc(ADDR_CONTROL, 8'hEF, 8'h06);
    wr(ADDR_CONFIG, 8'h8F);
    rc(ADDR_CONFIG, 8'hFF, 8'h00);
    $display("test reset views done");
  endtask

  // burst of two bytes plus a colliding third write
  task automatic t_xfer(input logic [7:0] rate, input logic [7:0] rep);
    int base;
    int i;
    base = n_rx;
    reply <= rep;
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_CONFIG, 8'h40);
    wr(ADDR_RATE, rate);
    @(posedge clk_in);
    nss_in <= 1'b0;
    wr(ADDR_DATA, 8'hA5);
    wr(ADDR_DATA, 8'h5A);
    rc(ADDR_CONTROL, 8'h42, 8'h00);
    rc(ADDR_CONFIG, 8'h80, 8'h80);
    wr(ADDR_DATA, 8'hFF);
    rc(ADDR_CONTROL, 8'h40, 8'h40);
    wait_rx(base + 1);
    check(got, 8'hA5);
    wait_rx(base + 2);
    check(got, 8'h5A);
    v = 8'h80;
    for (i = 0; i < 200 && v[7]; i++) rc(ADDR_CONFIG, 8'h40, 8'h40);
    if (v[7]) hung();
    check(v, 8'h40);
    repeat (40) @(posedge clk_in);
    check(8'(n_rx - base), 8'h02);
    rc(ADDR_DATA, 8'hFF, rep);
    rc(ADDR_CONTROL, 8'hEF, 8'hC3);
    check({7'h00, irq_out}, 8'h01);
    repeat (20) @(posedge clk_in);
    rc(ADDR_CONTROL, 8'hE0, 8'hC0);
    wr(ADDR_CONTROL, 8'h01);
    rc(ADDR_CONTROL, 8'hEF, 8'h03);
    check({7'h00, irq_out}, 8'h00);
    @(posedge clk_in);
    nss_in <= 1'b1;
    $display("test transfer at rate %0d done", rate);
  endtask

  // idle level follows polarity; long waits keep toggles apart
  task automatic t_pol();
    wr(ADDR_CONFIG, 8'h50);
    repeat (320) @(posedge clk_in);
    #1 check({7'h00, sck_out}, 8'h01);
    wr(ADDR_CONFIG, 8'h40);
    repeat (320) @(posedge clk_in);
    #1 check({7'h00, sck_out}, 8'h00);
    $display("test polarity done");
  endtask

  task automatic t_fault();
    wr(ADDR_CONTROL, 8'h05);
    @(posedge clk_in);
    nss_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1 check({7'h00, irq_out}, 8'h01);
    rc(ADDR_CONTROL, 8'hE1, 8'h20);
    rc(ADDR_CONFIG, 8'h40, 8'h00);
    @(posedge clk_in);
    nss_in <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    $display("test mode fault done");
  endtask

  // master set but port disabled: a data write must not go out
  task automatic t_off();
    int base;
    base = n_rx;
    wr(ADDR_CONFIG, 8'h40);
    @(posedge clk_in);
    nss_in <= 1'b0;
    wr(ADDR_DATA, 8'h77);
    repeat (100) @(posedge clk_in);
    #1 check({7'h00, sck_out}, 8'h00);
    check(8'(n_rx - base), 8'h00);
    rc(ADDR_CONFIG, 8'h80, 8'h00);
    rc(ADDR_CONTROL, 8'h80, 8'h00);
    $display("test disabled port done");
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_xfer(8'h00, 8'h3C);
    t_xfer(8'h14, 8'hC3);
    t_pol();
    t_fault();
    t_off();
    report_and_stop();
  end
endmodule
